// ==== hdl/rpsc_pkg.sv ====
package rpsc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_NUM = 8'h04;
  localparam logic [7:0] OFS_DEN = 8'h08;
  localparam logic [7:0] OFS_SEED = 8'h0C;
  localparam logic [7:0] OFS_STEP0 = 8'h10;
  localparam logic [7:0] OFS_STEP1 = 8'h14;
  localparam logic [7:0] OFS_LEN = 8'h18;
  localparam logic [7:0] OFS_THRESH = 8'h1C;
  localparam logic [7:0] OFS_FLOOR = 8'h20;
  localparam logic [7:0] OFS_CEIL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_RAMP = 8'h2C;
  localparam logic [7:0] OFS_PHASE = 8'h30;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_SYNC_EN = 0;
  localparam int CTRL_PIN_DIS = 1;
  localparam int CTRL_LVDS = 2;
  localparam int CTRL_SWEEP_EN = 3;
  localparam int CTRL_PIN_MODE = 4;
  localparam int CTRL_RECAL_SEG = 5;
  localparam int CTRL_START = 6;
  localparam int CTRL_OUTA_LSB = 8;
  localparam int CTRL_OUTB_LSB = 10;
  localparam int CTRL_STAGE_LSB = 12;
  localparam int CTRL_ORDER_LSB = 16;
  localparam logic [1:0] SRC_CHDIV = 2'h1;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_2002;
  localparam logic [31:0] DEN_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] CEIL_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] FLOOR_RST = 32'h8000_0000;
  localparam logic [31:0] EFF_DEN = 32'h0100_0000;
  localparam int STEP_W = 30;

  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_AUTO = 3'h2,
    RS_MAN = 3'h4
  } rpsc_ramp_e;

endpackage : rpsc_pkg

// ==== hdl/rpsc_pin_if.sv ====
`timescale 1ns/1ns
interface rpsc_pin_if;
  logic lvds_mode;
  logic sync_rise;
  logic step_rise;
  logic dir_level;
  modport cond (input lvds_mode, output sync_rise, output step_rise, output dir_level);
  modport core (output lvds_mode, input sync_rise, input step_rise, input dir_level);
endinterface : rpsc_pin_if

// ==== hdl/rpsc_pin_cond.sv ====
`timescale 1ns/1ns
module rpsc_pin_cond (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SYNC_P,
  input wire logic SYNC_N,
  input wire logic STEP,
  input wire logic DIR,
  rpsc_pin_if.cond pins
);

  typedef struct packed {
    logic sync_lvl;
    logic step_lvl;
    logic dir;
    logic sync_rise;
    logic step_rise;
  } rpsc_pc_s;

  rpsc_pc_s s_q;
  rpsc_pc_s s_d;
  logic sync_now;

  // ****************************************
  // Edge detection
  // ****************************************
  always_comb begin
    sync_now = pins.lvds_mode ? (SYNC_P & ~SYNC_N) : SYNC_P;
    s_d = s_q;
    s_d.sync_lvl = sync_now;
    s_d.step_lvl = STEP;
    s_d.dir = DIR;
    s_d.sync_rise = sync_now & ~s_q.sync_lvl;
    s_d.step_rise = STEP & ~s_q.step_lvl;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.sync_rise = s_q.sync_rise;
  assign pins.step_rise = s_q.step_rise;
  assign pins.dir_level = s_q.dir;

endmodule : rpsc_pin_cond

// ==== hdl/rpsc_top.sv ====
// Behaviour
// - Included divide is twice first stage if a source picks channel divider.
// - The first write of sync enable to one only enters mode, no sync applied.
// - Sync applied by enable 0-to-1 toggle or sync pin rising edge.
// - Sync pin accepted as single-ended or differential input.
// - Each seed write shifts phase by seed, scaled by included divide in sync.
// - No ramping at all unless sweep enable is one.
// - Pin mode zero steps on detector tick, one on step pin rising edges.
// - Each ramp clock adds the selected signed step to the numerator; here ramp clocks are ignored while a calibration is busy.
// - Each segment lasts one detector cycle more than its programmed length.
// - Numerator drift of at least a nonzero delta limit forces a calibration; a zero limit forces none.
// - Recalibrate each segment starts calibration at segment start, automatic only.
// - Host programs all-ones denominator; ramping uses two to the 24.
// - Ramped value clamps between signed floor and ceiling.
// - Automatic mode alternates between its two linear segments unattended, without stopping.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module rpsc_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SYNC_P,
  input wire logic SYNC_N,
  input wire logic REF_TICK,
  input wire logic PD_TICK,
  input wire logic STEP_CLK,
  input wire logic STEP_DIR,
  input wire logic CAL_DONE,
  output logic CAL_START,
  output logic SYNC_APPLY,
  output logic [31:0] NUMERATOR,
  output logic [31:0] DENOMINATOR,
  output logic [31:0] PHASE_OFFSET,
  output logic [4:0] INCLUDED_DIV
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] ctrl;
    logic [31:0] numer;
    logic [31:0] den;
    logic [31:0] seed;
    logic [29:0] step0;
    logic [29:0] step1;
    logic [15:0] len0;
    logic [15:0] len1;
    logic [31:0] thresh;
    logic [31:0] floor_v;
    logic [31:0] ceil_v;
    logic [31:0] acc;
    logic [31:0] cal_ref;
    logic [31:0] phase;
    logic [31:0] den_eff;
    logic [4:0] incl;
    logic seg;
    logic [15:0] seg_cnt;
    rpsc_pkg::rpsc_ramp_e rs;
    logic cal_busy;
    logic cal_start;
    logic armed;
    logic sync_pend;
    logic sync_apply;
    logic [7:0] sync_cnt;
  } rpsc_top_s;

  rpsc_top_s s_q;
  rpsc_top_s s_d;
  rpsc_pin_if pins ();

  logic setup;
  logic wr;
  logic [31:0] wval;
  logic [31:0] stepv;
  logic [31:0] drift;
  logic chdiv_used;
  logic advance;
  logic cal_req;
  logic new_en;
  logic [31:0] status;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] sext_step(input logic [29:0] v);
    sext_step = {{2{v[29]}}, v};
  endfunction : sext_step

  function automatic logic src_is_chdiv(input logic [1:0] sel);
    src_is_chdiv = (sel == rpsc_pkg::SRC_CHDIV);
  endfunction : src_is_chdiv

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= rpsc_pkg::OFS_PHASE) && (a[1:0] == 2'h0);
  endfunction : mapped

  function automatic logic [31:0] clamp(input logic [31:0] a, input logic [31:0] d,
                                        input logic [31:0] lo, input logic [31:0] hi);
    logic signed [32:0] sum;
    sum = $signed({a[31], a}) + $signed({d[31], d});
    if (sum < $signed({lo[31], lo})) begin
      clamp = lo;
    end else if (sum > $signed({hi[31], hi})) begin
      clamp = hi;
    end else begin
      clamp = sum[31:0];
    end
  endfunction : clamp

  // ****************************************
  // Pin conditioning
  // ****************************************
  rpsc_pin_cond u_pin (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .SYNC_P(SYNC_P),
    .SYNC_N(SYNC_N),
    .STEP(STEP_CLK),
    .DIR(STEP_DIR),
    .pins(pins.cond)
  );

  assign pins.lvds_mode = s_q.ctrl[rpsc_pkg::CTRL_LVDS];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    setup = PSEL & ~PENABLE;
    wr = PSEL & PENABLE & s_q.pready & PWRITE & ~s_q.pslverr;
    wval = PWDATA;
    stepv = 32'h0000_0000;
    drift = 32'h0000_0000;
    advance = 1'b0;
    cal_req = 1'b0;
    new_en = s_q.ctrl[rpsc_pkg::CTRL_SYNC_EN];
    s_d.cal_start = 1'b0;
    s_d.sync_apply = 1'b0;

    // APB slave, one access cycle
    s_d.pready = setup;
    s_d.pslverr = setup & ~mapped(PADDR);

    // Status word
    status = 32'h0000_0000;
    status[31:24] = s_q.sync_cnt;
    status[23:21] = s_q.rs;
    status[20:16] = s_q.incl;
    status[15:4] = s_q.seg_cnt[11:0];
    status[2] = s_q.armed;
    status[1] = s_q.sync_pend;
    status[0] = s_q.seg;

    if (setup) begin
      unique case (PADDR)
        rpsc_pkg::OFS_CTRL: s_d.prdata = s_q.ctrl;
        rpsc_pkg::OFS_NUM: s_d.prdata = s_q.numer;
        rpsc_pkg::OFS_DEN: s_d.prdata = s_q.den;
        rpsc_pkg::OFS_SEED: s_d.prdata = s_q.seed;
        rpsc_pkg::OFS_STEP0: s_d.prdata = {2'h0, s_q.step0};
        rpsc_pkg::OFS_STEP1: s_d.prdata = {2'h0, s_q.step1};
        rpsc_pkg::OFS_LEN: s_d.prdata = {s_q.len1, s_q.len0};
        rpsc_pkg::OFS_THRESH: s_d.prdata = s_q.thresh;
        rpsc_pkg::OFS_FLOOR: s_d.prdata = s_q.floor_v;
        rpsc_pkg::OFS_CEIL: s_d.prdata = s_q.ceil_v;
        rpsc_pkg::OFS_STATUS: s_d.prdata = status;
        rpsc_pkg::OFS_RAMP: s_d.prdata = s_q.acc;
        rpsc_pkg::OFS_PHASE: s_d.prdata = s_q.phase;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (wr) begin
      unique case (PADDR)
        rpsc_pkg::OFS_CTRL: begin
          s_d.ctrl = {wval[31:rpsc_pkg::CTRL_START + 1], 1'b0, wval[rpsc_pkg::CTRL_START - 1:0]};
          new_en = wval[rpsc_pkg::CTRL_SYNC_EN];
        end
        rpsc_pkg::OFS_NUM: begin
          s_d.numer = wval;
          s_d.acc = wval;
        end
        rpsc_pkg::OFS_DEN: s_d.den = wval;
        rpsc_pkg::OFS_SEED: begin
          s_d.seed = wval;
          // Phase moves by seed, scaled by the included divide in sync mode
          if (s_q.ctrl[rpsc_pkg::CTRL_SYNC_EN]) begin
            s_d.phase = s_q.phase + 32'(wval * s_q.incl);
          end else begin
            s_d.phase = s_q.phase + wval;
          end
        end
        rpsc_pkg::OFS_STEP0: s_d.step0 = wval[rpsc_pkg::STEP_W - 1:0];
        rpsc_pkg::OFS_STEP1: s_d.step1 = wval[rpsc_pkg::STEP_W - 1:0];
        rpsc_pkg::OFS_LEN: begin
          s_d.len0 = wval[15:0];
          s_d.len1 = wval[31:16];
        end
        rpsc_pkg::OFS_THRESH: s_d.thresh = wval;
        rpsc_pkg::OFS_FLOOR: s_d.floor_v = wval;
        rpsc_pkg::OFS_CEIL: s_d.ceil_v = wval;
        default: begin
        end
      endcase
    end

    // ****************************************
    // Included divide and effective denominator
    // ****************************************
    chdiv_used = src_is_chdiv(s_q.ctrl[rpsc_pkg::CTRL_OUTA_LSB +: 2]) ||
                 src_is_chdiv(s_q.ctrl[rpsc_pkg::CTRL_OUTB_LSB +: 2]);
    s_d.incl = chdiv_used ? {s_q.ctrl[rpsc_pkg::CTRL_STAGE_LSB +: 4], 1'b0} : 5'h01;
    s_d.den_eff = s_q.ctrl[rpsc_pkg::CTRL_SWEEP_EN] ? rpsc_pkg::EFF_DEN : s_q.den;

    // ****************************************
    // Synchronization
    // ****************************************
    // Apply first so that a new request in the same cycle wins
    if (s_q.sync_pend && REF_TICK) begin
      s_d.sync_pend = 1'b0;
      s_d.sync_apply = 1'b1;
      s_d.sync_cnt = s_q.sync_cnt + 8'h01;
    end
    if (new_en && !s_q.ctrl[rpsc_pkg::CTRL_SYNC_EN]) begin
      if (s_q.armed) begin
        s_d.sync_pend = 1'b1;
      end
      s_d.armed = 1'b1;
    end
    if (s_q.ctrl[rpsc_pkg::CTRL_SYNC_EN] && !s_q.ctrl[rpsc_pkg::CTRL_PIN_DIS]
        && pins.sync_rise) begin
      s_d.sync_pend = 1'b1;
    end

    // ****************************************
    // Ramp generator
    // ****************************************
    if (CAL_DONE) begin
      s_d.cal_busy = 1'b0;
    end
    if (!s_q.ctrl[rpsc_pkg::CTRL_SWEEP_EN]) begin
      s_d.rs = rpsc_pkg::RS_IDLE;
    end else begin
      unique case (s_q.rs)
        rpsc_pkg::RS_IDLE: begin
          if (s_q.ctrl[rpsc_pkg::CTRL_PIN_MODE]) begin
            s_d.rs = rpsc_pkg::RS_MAN;
          end else if (wr && PADDR == rpsc_pkg::OFS_CTRL && wval[rpsc_pkg::CTRL_START]) begin
            s_d.rs = rpsc_pkg::RS_AUTO;
            s_d.seg = 1'b0;
            s_d.seg_cnt = 16'h0000;
            cal_req = s_q.ctrl[rpsc_pkg::CTRL_RECAL_SEG];
          end
        end
        rpsc_pkg::RS_AUTO: begin
          if (s_q.ctrl[rpsc_pkg::CTRL_PIN_MODE]) begin
            s_d.rs = rpsc_pkg::RS_IDLE;
          end else if (PD_TICK && !s_q.cal_busy) begin
            advance = 1'b1;
            stepv = sext_step(s_q.seg ? s_q.step1 : s_q.step0);
            if (s_q.seg_cnt >= (s_q.seg ? s_q.len1 : s_q.len0)) begin
              s_d.seg = ~s_q.seg;
              s_d.seg_cnt = 16'h0000;
              cal_req = s_q.ctrl[rpsc_pkg::CTRL_RECAL_SEG];
            end else begin
              s_d.seg_cnt = s_q.seg_cnt + 16'h0001;
            end
          end
        end
        rpsc_pkg::RS_MAN: begin
          if (!s_q.ctrl[rpsc_pkg::CTRL_PIN_MODE]) begin
            s_d.rs = rpsc_pkg::RS_IDLE;
          end else if (pins.step_rise && !s_q.cal_busy) begin
            advance = 1'b1;
            stepv = sext_step(pins.dir_level ? s_q.step1 : s_q.step0);
          end
        end
        default: s_d.rs = rpsc_pkg::RS_IDLE;
      endcase
    end

    if (advance) begin
      s_d.acc = clamp(s_q.acc, stepv, s_q.floor_v, s_q.ceil_v);
      drift = s_d.acc - s_q.cal_ref;
      if (drift[31]) begin
        drift = 32'h0000_0000 - drift;
      end
      if (s_q.thresh != 32'h0000_0000 && drift >= s_q.thresh) begin
        cal_req = 1'b1;
      end
    end
    if (cal_req) begin
      s_d.cal_start = 1'b1;
      s_d.cal_busy = 1'b1;
      s_d.cal_ref = s_d.acc;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.ctrl <= rpsc_pkg::CTRL_RST;
      s_q.den <= rpsc_pkg::DEN_RST;
      s_q.den_eff <= rpsc_pkg::DEN_RST;
      s_q.floor_v <= rpsc_pkg::FLOOR_RST;
      s_q.ceil_v <= rpsc_pkg::CEIL_RST;
      s_q.incl <= 5'h01;
      s_q.rs <= rpsc_pkg::RS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign CAL_START = s_q.cal_start;
  assign SYNC_APPLY = s_q.sync_apply;
  assign NUMERATOR = s_q.acc;
  assign DENOMINATOR = s_q.den_eff;
  assign PHASE_OFFSET = s_q.phase;
  assign INCLUDED_DIV = s_q.incl;

endmodule : rpsc_top

// ==== testbench/rpsc_chk.sv ====
`timescale 1ns/1ns
module rpsc_chk (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic REF_TICK,
  input wire logic CAL_START,
  input wire logic SYNC_APPLY,
  input wire logic [31:0] NUMERATOR,
  input wire logic [31:0] DENOMINATOR,
  input wire logic [4:0] INCLUDED_DIV
);
  // ****
  // Shadow of written fields
  // ****
  logic wr;
  logic [31:0] ctrl_q;
  logic [31:0] ceil_q;
  logic [31:0] floor_q;
  logic [4:0] div_e;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign div_e = (ctrl_q[9:8] == rpsc_pkg::SRC_CHDIV || ctrl_q[11:10] == rpsc_pkg::SRC_CHDIV)
    ? {ctrl_q[15:12], 1'b0} : 5'h01;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= rpsc_pkg::CTRL_RST;
      ceil_q <= rpsc_pkg::CEIL_RST;
      floor_q <= rpsc_pkg::FLOOR_RST;
    end else if (wr) begin
      if (PADDR == rpsc_pkg::OFS_CTRL)
        ctrl_q <= PWDATA;
      if (PADDR == rpsc_pkg::OFS_CEIL)
        ceil_q <= PWDATA;
      if (PADDR == rpsc_pkg::OFS_FLOOR)
        floor_q <= PWDATA;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_ctrl_wr;
    wr && PADDR == rpsc_pkg::OFS_CTRL;
  endsequence
  a_ready_one: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_drop: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_slverr_map: assert property (s_setup |=> PSLVERR == (PADDR > 8'h30 || PADDR[1:0] != 2'h0))
    else $error("slave error wrong");
  a_incl_div: assert property (s_ctrl_wr |-> ##2 INCLUDED_DIV == div_e)
    else $error("included divide wrong");
  a_den_sweep: assert property (s_ctrl_wr ##0 PWDATA[3] |-> ##2 DENOMINATOR == rpsc_pkg::EFF_DEN)
    else $error("effective denominator wrong");
  a_apply_ref: assert property (SYNC_APPLY |-> $past(REF_TICK) ##1 !SYNC_APPLY)
    else $error("sync apply not on reference");
  a_cal_pulse: assert property (CAL_START |=> !CAL_START)
    else $error("calibration request too long");
  a_no_ramp: assert property (!ctrl_q[3] && !wr && !$past(wr) |=> $stable(NUMERATOR))
    else $error("numerator moved with sweep off");
  a_clamp_lim: assert property (ctrl_q[3] && !wr && !$past(wr) |->
    $signed(NUMERATOR) <= $signed(ceil_q) && $signed(NUMERATOR) >= $signed(floor_q))
    else $error("numerator outside limits");
endmodule : rpsc_chk
bind rpsc_top rpsc_chk u_rpsc_chk (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .REF_TICK(REF_TICK),
  .CAL_START(CAL_START),
  .SYNC_APPLY(SYNC_APPLY),
  .NUMERATOR(NUMERATOR),
  .DENOMINATOR(DENOMINATOR),
  .INCLUDED_DIV(INCLUDED_DIV)
);

// ==== testbench/rpsc_host.sv ====
`timescale 1ns/1ns
module rpsc_host (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CAL_START,
  input wire logic pd_en,
  output logic SYNC_P,
  output logic SYNC_N,
  output logic REF_TICK,
  output logic PD_TICK,
  output logic STEP_CLK,
  output logic STEP_DIR,
  output logic CAL_DONE
);
  int n = 0;
  logic [2:0] cq;
  initial begin
    {SYNC_P, REF_TICK, PD_TICK, STEP_CLK, STEP_DIR, CAL_DONE, cq} = 0;
    SYNC_N = 1'b1;
  end
  // ****
  // Ticks and calibrator answer
  // ****
  always @(posedge CLK) begin
    n <= RESET_N ? n + 1 : 0;
    REF_TICK <= n % 5 == 0;
    PD_TICK <= pd_en && n % 4 == 2;
    cq <= {cq[1:0], CAL_START};
    CAL_DONE <= cq[2];
  end
  task automatic sync();
    while (n % 5 != 2) @(posedge CLK);
    SYNC_P <= 1'b1;
    SYNC_N <= 1'b0;
    repeat (4) @(posedge CLK);
    SYNC_P <= 1'b0;
    SYNC_N <= 1'b1;
  endtask : sync
  task automatic step(input logic d);
    STEP_DIR <= d;
    @(posedge CLK);
    STEP_CLK <= 1'b1;
    repeat (3) @(posedge CLK);
    STEP_CLK <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask : step
endmodule : rpsc_host

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SYNC_APPLY, CAL_START, pd_en;
  logic SYNC_P, SYNC_N, REF_TICK, PD_TICK, STEP_CLK, STEP_DIR, CAL_DONE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, NUMERATOR, DENOMINATOR, PHASE_OFFSET, s1, e;
  logic [4:0] INCLUDED_DIV;
  logic [33:0] nt;
  logic [33:0] q[$];
  int fails = 0;
  int checked = 0;
  int syncs = 0;
  int cals = 0;
  int tk = 0;
  int s, c;
  integer sd = 32'h5713470d;
  rpsc_top u_rpsc_top (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYNC_P(SYNC_P), .SYNC_N(SYNC_N), .REF_TICK(REF_TICK), .PD_TICK(PD_TICK),
    .STEP_CLK(STEP_CLK), .STEP_DIR(STEP_DIR), .CAL_DONE(CAL_DONE), .CAL_START(CAL_START),
    .SYNC_APPLY(SYNC_APPLY), .NUMERATOR(NUMERATOR), .DENOMINATOR(DENOMINATOR),
    .PHASE_OFFSET(PHASE_OFFSET), .INCLUDED_DIV(INCLUDED_DIV)
  );
  rpsc_host u_rpsc_host (
    .CLK(CLK), .RESET_N(RESET_N), .CAL_START(CAL_START), .pd_en(pd_en),
    .SYNC_P(SYNC_P), .SYNC_N(SYNC_N), .REF_TICK(REF_TICK), .PD_TICK(PD_TICK),
    .STEP_CLK(STEP_CLK), .STEP_DIR(STEP_DIR), .CAL_DONE(CAL_DONE)
  );
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // ****
  // Checks and bus
  // ****
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  always @(posedge CLK) begin
    if (SYNC_APPLY === 1'b1)
      syncs++;
    if (CAL_START === 1'b1)
      cals++;
    if (PD_TICK === 1'b1)
      tk++;
    if (PREADY === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      chk({PSLVERR, nt[33] ? PRDATA : 32'h0}, nt[32:0]);
    end
  end
  task automatic apb(input logic wt_, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    q.push_back(x);
    PSEL <= 1'b1;
    PWRITE <= wt_;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, {2'b10, d});
  endtask : r
  task automatic wt(input int k);
    repeat (k) @(posedge CLK);
  endtask : wt
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    #40000;
    fails++;
    summarize();
  end
  // ****
  // Tests
  // ****
  initial begin
    {RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, pd_en} = 0;
    wt(12);
    RESET_N <= 1'b1;
    wt(1);
    chk(INCLUDED_DIV, 1);
    r(rpsc_pkg::OFS_DEN, rpsc_pkg::DEN_RST);
    r(rpsc_pkg::OFS_FLOOR, rpsc_pkg::FLOOR_RST);
    r(rpsc_pkg::OFS_CEIL, rpsc_pkg::CEIL_RST);
    apb(1'b1, 8'h02, 32'hFFFF_FFFF, 34'h1_0000_0000);
    apb(1'b0, 8'h34, 32'h0, 34'h3_0000_0000);
    r(rpsc_pkg::OFS_CTRL, rpsc_pkg::CTRL_RST);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      s = {$random(sd)} % 15 + 1;
      w(rpsc_pkg::OFS_CTRL, 32'(s << 12 | i << 8 | 2));
      wt(3);
      chk(INCLUDED_DIV, (i % 4 == 1 || i / 4 == 1) ? 2 * s : 1);
    end
    $display("test divide done");
    w(rpsc_pkg::OFS_CTRL, 32'h1_3102);
    s1 = $random(sd) & 32'hFFFF;
    w(rpsc_pkg::OFS_SEED, s1);
    wt(3);
    chk(PHASE_OFFSET, s1);
    w(rpsc_pkg::OFS_CTRL, 32'h1_3101);
    wt(20);
    chk(syncs, 0);
    w(rpsc_pkg::OFS_SEED, s1);
    wt(3);
    chk(PHASE_OFFSET, s1 * 7);
    u_rpsc_host.sync();
    wt(20);
    chk(syncs, 1);
    w(rpsc_pkg::OFS_CTRL, 32'h1_3105);
    u_rpsc_host.sync();
    wt(20);
    chk(syncs, 2);
    w(rpsc_pkg::OFS_CTRL, 32'h1_3102);
    w(rpsc_pkg::OFS_CTRL, 32'h1_3101);
    wt(20);
    chk(syncs, 3);
    w(rpsc_pkg::OFS_CTRL, 32'h1_3103);
    u_rpsc_host.sync();
    wt(20);
    chk(syncs, 3);
    $display("test sync done");
    s = {$random(sd)} % 200 + 1;
    w(rpsc_pkg::OFS_CTRL, 32'h2);
    w(rpsc_pkg::OFS_NUM, 1000);
    w(rpsc_pkg::OFS_STEP0, s);
    w(rpsc_pkg::OFS_STEP1, 32'h3FFF_FFCE);
    u_rpsc_host.step(1'b0);
    chk(NUMERATOR, 1000);
    w(rpsc_pkg::OFS_CTRL, 32'h1A);
    wt(2);
    chk(DENOMINATOR, rpsc_pkg::EFF_DEN);
    u_rpsc_host.step(1'b0);
    u_rpsc_host.step(1'b1);
    chk(NUMERATOR, 950 + s);
    w(rpsc_pkg::OFS_CEIL, 1010 + s);
    w(rpsc_pkg::OFS_FLOOR, 950 + s);
    u_rpsc_host.step(1'b0);
    chk(NUMERATOR, (s > 60) ? 1010 + s : 950 + 2 * s);
    u_rpsc_host.step(1'b1);
    u_rpsc_host.step(1'b1);
    chk(NUMERATOR, 950 + s);
    w(rpsc_pkg::OFS_FLOOR, rpsc_pkg::FLOOR_RST);
    w(rpsc_pkg::OFS_THRESH, 120);
    c = cals;
    repeat (4) u_rpsc_host.step(1'b1);
    chk(cals > c, 1);
    $display("test ramp done");
    w(rpsc_pkg::OFS_THRESH, 0);
    w(rpsc_pkg::OFS_CTRL, 32'h2);
    w(rpsc_pkg::OFS_NUM, 500);
    w(rpsc_pkg::OFS_STEP0, 1);
    w(rpsc_pkg::OFS_STEP1, 3);
    w(rpsc_pkg::OFS_LEN, 32'h0001_0001);
    w(rpsc_pkg::OFS_CTRL, 32'h0A);
    w(rpsc_pkg::OFS_CTRL, 32'h4A);
    tk = 0;
    pd_en <= 1'b1;
    wt(40);
    pd_en <= 1'b0;
    wt(5);
    e = 500;
    for (int t = 0; t < tk; t++)
      e += t[1] ? 3 : 1;
    chk(NUMERATOR, e);
    u_rpsc_host.step(1'b0);
    chk(NUMERATOR, e);
    w(rpsc_pkg::OFS_CTRL, 32'h22);
    w(rpsc_pkg::OFS_CTRL, 32'h2A);
    c = cals;
    w(rpsc_pkg::OFS_CTRL, 32'h6A);
    wt(10);
    chk(cals > c, 1);
    $display("test auto done");
    summarize();
  end
endmodule : tb
